/* hdl/mps_sequencer.sv */
/*
  Mirror-array power sequencer: request deglitch, rail sequencing, fault
  power-down, system reset, colour decode gating and a serial config port.
  Assumes pins are asynchronous to clock_i; the serial clock is sampled.
*/
`timescale 1ns/100ps
`include "mps_params.svh"
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int PWR_DGL_CYC   = `MPS_PWR_DGL_CYC,
  parameter int INIT_CYC      = `MPS_INIT_CYC,
  parameter int OFS_WAIT_CYC  = `MPS_OFS_WAIT_CYC,
  parameter int DOWN_STEP_CYC = `MPS_DOWN_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Pins from the display controller
  input  wire logic       power_request_in_i,
  input  wire logic       colour_select_bit0_i,
  input  wire logic       colour_select_bit1_i,
  input  wire logic [2:0] rail_fault_i,
  // Serial link
  input  wire logic       spi_clk_i,
  input  wire logic       spi_csn_i,
  input  wire logic       spi_din_i,
  output logic            spi_dout_o,
  output logic            spi_dout_oe_o,
  // Rails, reset, interrupt
  output logic            mirror_offset_rail_o,
  output logic            mirror_bias_rail_o,
  output logic            mirror_reset_rail_o,
  output logic            mirror_array_init_o,
  output logic            system_reset_n_o,
  output logic            interrupt_n_o,
  // LED path
  output logic            led_driver_en_o,
  output logic [2:0]      led_switch_o,
  output logic [9:0]      led_current_o
);
  localparam int SELC = `MPS_SEL_DGL_CYC;

  // Refuse counts that the 28-bit timers or the 8-bit filter cannot hold
  if (PWR_DGL_CYC < 2 || INIT_CYC < 1 || OFS_WAIT_CYC < 1 ||
      DOWN_STEP_CYC < 1 || PWR_DGL_CYC > 28'hFFF_FFFF ||
      INIT_CYC > 28'hFFF_FFFF || OFS_WAIT_CYC > 28'hFFF_FFFF ||
      DOWN_STEP_CYC > 28'hFFF_FFFF || SELC < 1 ||
      SELC > 8'hFF) begin : g_bad_counts
    $error("mps_sequencer: counts out of range");
  end

  // Two-stage synchronisers for every pin
  logic [6:0] s1_reg, s2_reg, s1_next;
  always_comb begin
    s1_next = {spi_din_i, spi_csn_i, spi_clk_i, colour_select_bit1_i,
               colour_select_bit0_i, power_request_in_i, |rail_fault_i};
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // Idle levels: select high, serial clock low, so no false edge
      s1_reg <= 7'h20;
      s2_reg <= 7'h20;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s1_reg;
    end
  end
  wire fault_s = s2_reg[0];
  wire preq_s  = s2_reg[1];
  wire sclk_s  = s2_reg[4];
  wire csn_s   = s2_reg[5];
  wire din_s   = s2_reg[6];

  // Deglitch filters: a level is taken once it holds for the full window
  logic        preq_reg, preq_next;
  logic [27:0] pcnt_reg, pcnt_next;
  logic [1:0]  sel_reg, sel_next, selc_reg, selc_next;
  logic [7:0]  scnt_reg, scnt_next;
  always_comb begin
    preq_next = preq_reg;
    pcnt_next = 28'h000_0000;
    if (preq_s != preq_reg) begin
      pcnt_next = pcnt_reg + 28'h000_0001;
      if (pcnt_reg == 28'(PWR_DGL_CYC - 1)) begin
        preq_next = preq_s;
        pcnt_next = 28'h000_0000;
      end
    end
    selc_next = s2_reg[3:2];
    sel_next  = sel_reg;
    scnt_next = 8'h00;
    if (s2_reg[3:2] == selc_reg && s2_reg[3:2] != sel_reg) begin
      scnt_next = scnt_reg + 8'h01;
      if (scnt_reg == 8'(SELC - 1))
        sel_next = selc_reg;
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      preq_reg <= 1'b0;
      pcnt_reg <= 28'h000_0000;
      sel_reg  <= 2'h0;
      selc_reg <= 2'h0;
      scnt_reg <= 8'h00;
    end else begin
      preq_reg <= preq_next;
      pcnt_reg <= pcnt_next;
      sel_reg  <= sel_next;
      selc_reg <= selc_next;
      scnt_reg <= scnt_next;
    end
  end

  // Serial port: shift in on rising, launch out on falling sampled edge
  logic        sclk_d_reg, sclk_d_next;
  logic [15:0] sh_reg, sh_next;
  logic [4:0]  bc_reg, bc_next;
  logic [9:0]  idac_reg [3];
  logic [9:0]  idac_next [3];
  logic [2:0]  mask_reg, mask_next;
  logic        dout_reg, dout_next, doe_reg, doe_next;
  logic [2:0]  fault_flag;
  always_comb begin
    sclk_d_next = sclk_s;
    sh_next     = sh_reg;
    bc_next     = bc_reg;
    idac_next   = idac_reg;
    mask_next   = mask_reg;
    dout_next   = dout_reg;
    doe_next    = !csn_s;
    if (csn_s) begin
      bc_next = 5'h00;
    end else if (sclk_s && !sclk_d_reg) begin
      sh_next = {sh_reg[14:0], din_s};
      bc_next = bc_reg + 5'h01;
      if (bc_reg == 5'h07) begin
        // Command byte seen: status leads the second byte out; the low
        // byte keeps the command so the end-of-frame decode ignores it
        if (sh_reg[6:3] == `MPS_CMD_STATUS)
          sh_next = {5'h00, fault_flag, sh_reg[6:0], din_s};
      end
      if (bc_reg == 5'h0F) begin
        case (sh_reg[14:11])
          `MPS_CMD_LED0: idac_next[0] = {sh_reg[8:0], din_s};
          `MPS_CMD_LED1: idac_next[1] = {sh_reg[8:0], din_s};
          `MPS_CMD_LED2: idac_next[2] = {sh_reg[8:0], din_s};
          `MPS_CMD_MASK: mask_next    = {sh_reg[1:0], din_s};
          default:       mask_next    = mask_reg;
        endcase
      end
    end else if (!sclk_s && sclk_d_reg) begin
      dout_next = sh_reg[15];
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_reg <= 1'b0;
      sh_reg     <= 16'h0000;
      bc_reg     <= 5'h00;
      idac_reg   <= '{`MPS_IDAC_RST, `MPS_IDAC_RST, `MPS_IDAC_RST};
      mask_reg   <= 3'h0;
      dout_reg   <= 1'b0;
      doe_reg    <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      sh_reg     <= sh_next;
      bc_reg     <= bc_next;
      idac_reg   <= idac_next;
      mask_reg   <= mask_next;
      dout_reg   <= dout_next;
      doe_reg    <= doe_next;
    end
  end
  assign fault_flag = {mask_reg[2], mask_reg[1], fault_s};

  // Sequencer: ordered power-up, normal and fast power-down
  mps_state_t  st_reg, st_next;
  logic [27:0] tc_reg, tc_next;
  logic        irq_reg, irq_next;
  always_comb begin
    st_next  = st_reg;
    tc_next  = tc_reg + 28'h000_0001;
    irq_next = irq_reg;
    case (st_reg)
      MPS_OFF: begin
        tc_next = 28'h000_0000;
        if (preq_reg && !fault_s) st_next = MPS_INIT;
      end
      MPS_INIT: if (tc_reg == 28'(INIT_CYC - 1)) begin
        st_next = MPS_OFS_ON;
        tc_next = 28'h000_0000;
      end
      MPS_OFS_ON: if (tc_reg == 28'(OFS_WAIT_CYC - 1)) begin
        st_next = MPS_READY;
        tc_next = 28'h000_0000;
      end
      MPS_READY: tc_next = 28'h000_0000;
      MPS_DOWN_BR: if (tc_reg == 28'(DOWN_STEP_CYC - 1)) begin
        st_next = MPS_DOWN_OFS;
        tc_next = 28'h000_0000;
      end
      MPS_DOWN_OFS: if (tc_reg == 28'(DOWN_STEP_CYC - 1)) begin
        st_next = MPS_OFF;
        tc_next = 28'h000_0000;
      end
      MPS_FAULT: begin
        tc_next = 28'h000_0000;
        if (!preq_reg) st_next = MPS_OFF;
      end
      default: st_next = MPS_OFF;
    endcase
    if (st_reg != MPS_OFF && st_reg != MPS_FAULT) begin
      if (fault_s) begin
        st_next = MPS_FAULT;
        tc_next = 28'h000_0000;
      end else if (!preq_reg && st_reg inside {MPS_INIT, MPS_OFS_ON,
                                               MPS_READY}) begin
        st_next = MPS_DOWN_BR;
        tc_next = 28'h000_0000;
      end
    end
    // Interrupt follows a fault unless masked; set wins over release
    if (fault_s && !mask_reg[0]) irq_next = 1'b1;
    else if (!preq_reg) irq_next = 1'b0;
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg  <= MPS_OFF;
      tc_reg  <= 28'h000_0000;
      irq_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      tc_reg  <= tc_next;
      irq_reg <= irq_next;
    end
  end

  // Registered outputs
  logic [11:0] out_reg, out_next;
  logic [9:0]  cur_reg, cur_next;
  always_comb begin
    out_next     = 12'h000;
    // A taken fault drops every rail on the same edge
    out_next[0]  = st_reg inside {MPS_OFS_ON, MPS_READY, MPS_DOWN_BR}
                   && st_next != MPS_FAULT;
    // Bias and reset rails go first on power-down, offset a step later
    out_next[1]  = st_reg == MPS_READY && st_next == MPS_READY;
    out_next[2]  = out_next[1];
    out_next[3]  = st_reg == MPS_INIT;
    out_next[5]  = !irq_reg;
    // LED path and system reset wait one cycle until all rails stand
    out_next[6]  = out_next[1] && out_reg[2:0] == 3'b111;
    out_next[4]  = out_next[6];
    cur_next     = 10'h000;
    if (out_next[6]) begin
      case (sel_reg)
        2'h1: begin out_next[7] = 1'b1; cur_next = idac_reg[0]; end
        2'h2: begin out_next[8] = 1'b1; cur_next = idac_reg[1]; end
        2'h3: begin out_next[9] = 1'b1; cur_next = idac_reg[2]; end
        default: cur_next = 10'h000;
      endcase
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_reg <= 12'h020;
      cur_reg <= 10'h000;
    end else begin
      out_reg <= out_next;
      cur_reg <= cur_next;
    end
  end
  assign mirror_offset_rail_o = out_reg[0];
  assign mirror_bias_rail_o   = out_reg[1];
  assign mirror_reset_rail_o  = out_reg[2];
  assign mirror_array_init_o  = out_reg[3];
  assign system_reset_n_o     = out_reg[4];
  assign interrupt_n_o        = out_reg[5];
  assign led_driver_en_o      = out_reg[6];
  assign led_switch_o         = out_reg[9:7];
  assign led_current_o        = cur_reg;
  assign spi_dout_o           = dout_reg;
  assign spi_dout_oe_o        = doe_reg;

  AST_LED_GATED: assert property (@(posedge clock_i) disable iff (!rstn_i)
    led_driver_en_o |-> mirror_offset_rail_o && mirror_bias_rail_o
    && mirror_reset_rail_o) else $error("LED on before rails");
  AST_SEL_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $past(sel_reg) == 2'h0 |-> led_switch_o == 3'h0 &&
    led_current_o == 10'h000) else $error("Code zero drove a switch");
  AST_FAST_DOWN: assert property (@(posedge clock_i) disable iff (!rstn_i)
    fault_s && st_reg inside {MPS_OFS_ON, MPS_READY} |=>
    !mirror_offset_rail_o && !mirror_bias_rail_o && !mirror_reset_rail_o)
    else $error("Rails not dropped together");
  AST_OFS_ORDER: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(mirror_bias_rail_o) |-> $past(mirror_offset_rail_o))
    else $error("Bias before offset");
  AST_INIT_FIRST: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(mirror_offset_rail_o) |-> $past(mirror_array_init_o, 2))
    else $error("Offset rail without init");
  AST_NORMAL_DOWN: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $fell(mirror_bias_rail_o) && !fault_s |-> mirror_offset_rail_o)
    else $error("Offset dropped first");
  AST_DOE: assert property (@(posedge clock_i) disable iff (!rstn_i)
    csn_s |-> ##1 !spi_dout_oe_o) else $error("Output driven idle");
  AST_RESET_OUT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    system_reset_n_o |-> led_driver_en_o) else $error("Reset early");
  AST_IRQ_MASK: assert property (@(posedge clock_i) disable iff (!rstn_i)
    mask_reg[0] && !irq_reg |=> !irq_reg || !mask_reg[0] || $past(!mask_reg[0]))
    else $error("Masked fault raised interrupt");
endmodule // mps_sequencer

/* hdl/mps_params.svh */
/*
  Timing constants and reset values for the mirror-array power sequencer.
  Assumes a 100 MHz system clock; included by the top module only.
*/
// Contract
// - Power request acts only after its level holds about 1 ms.
// - Colour-select bits ignore level changes shorter than about 300 ns.
// - After request rises, initialise mirror array, then offset rail within 10 ms.
// - Bias and reset rails enable 145 ms after the offset rail.
// - LED driver and colour decoder stay off until all three rails are on.
// - Request low starts the normal ordered power-down of the rails.
// - Any rail fault starts fast power-down, all rails discharged together.
// - The block generates the system reset output.
// - Three independent 10-bit LED current settings, written over the serial link.
// - Serial output updates after each falling serial clock edge while selected.
// - Serial output goes high impedance when select is high.
// - Masked fault keeps interrupt high; fault shutdown timing unchanged.
// - Colour code zero opens all switches and applies no current.
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
`define MPS_CLK_MHZ        100
`define MPS_PWR_DGL_US     1000
`define MPS_SEL_DGL_NS     300
`define MPS_INIT_US        1000
`define MPS_OFS_WAIT_US    145000
`define MPS_DOWN_STEP_US   1000
`define MPS_CLK_NS         10
// Counts in cycles; 10 % oscillator margin added to least waits
`define MPS_PWR_DGL_CYC    ((`MPS_PWR_DGL_US * `MPS_CLK_MHZ * 11) / 10)
`define MPS_SEL_DGL_CYC    ((`MPS_SEL_DGL_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`define MPS_INIT_CYC       (`MPS_INIT_US * `MPS_CLK_MHZ)
`define MPS_OFS_WAIT_CYC   ((`MPS_OFS_WAIT_US * `MPS_CLK_MHZ * 11) / 10)
`define MPS_DOWN_STEP_CYC  (`MPS_DOWN_STEP_US * `MPS_CLK_MHZ)
`define MPS_CMD_LED0       4'h1
`define MPS_CMD_LED1       4'h2
`define MPS_CMD_LED2       4'h3
`define MPS_CMD_MASK       4'h4
`define MPS_CMD_STATUS     4'h5
`define MPS_IDAC_RST       10'h000
`endif

/* hdl/mps_pkg.sv */
/*
  Types for the mirror-array power sequencer.
  Assumes nothing beyond the shared parameter header.
*/
package mps_pkg;
  typedef enum logic [2:0] {
    MPS_OFF      = 3'b000,
    MPS_INIT     = 3'b001,
    MPS_OFS_ON   = 3'b010,
    MPS_READY    = 3'b011,
    MPS_DOWN_BR  = 3'b100,
    MPS_DOWN_OFS = 3'b101,
    MPS_FAULT    = 3'b110
  } mps_state_t;
endpackage

/* sim/mps_ctrl_model.sv */
/*
  Controller-side model of the serial link, sending 16-bit frames.
  Assumes the block samples din on rising sclk and shifts on falling.
*/
`timescale 1ns/100ps
module mps_ctrl_model (
  // Serial link
  output logic      spi_clk_o,
  output logic      spi_csn_o,
  output logic      spi_din_o,
  input  wire logic spi_dout_i
);
  logic [15:0] rx_reg;
  // Idle link: clock low, select high
  initial begin
    spi_clk_o = 1'b0;
    spi_csn_o = 1'b1;
    spi_din_o = 1'b0;
    rx_reg    = 16'h0000;
  end
  // One frame, MSB first; the clock stands still between frames
  task automatic send(input logic [15:0] word);
    spi_csn_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_din_o = word[i];                  // Launch after fall
      #80 spi_clk_o = 1'b1;
      #80 spi_clk_o = 1'b0;
      rx_reg = {rx_reg[14:0], spi_dout_i};  // Capture on fall
    end
    #80 spi_csn_o = 1'b1;
    spi_din_o = ~spi_din_o;  // Released line must not hold stale data
    #160;  // Idle gap so the block sees select high between frames
  endtask
endmodule // mps_ctrl_model

/* sim/mps_sequencer_tb.sv */
/*
  Self-checking bench for the mirror-array power sequencer.
  Assumes shortened counts; a serial model drives the link.
*/
`timescale 1ns/100ps
module mps_sequencer_tb;
  localparam int PWR  = 20;
  localparam int OFSW = 50;
  // Pins, outputs and bookkeeping
  logic       clock_i, rstn_i, preq, sel0, sel1;
  logic [2:0] fault;
  wire        sclk, csn, din, dout, dout_oe, ofs, bias, rrail;
  wire        init, sys_n, int_n, led_en;
  wire  [2:0] sw;
  wire  [9:0] cur;
  wire  [4:0] mon = {bias, ofs, init, sys_n, led_en};
  int         fail_count, compares, n;
  logic [9:0] exp_cur [4] = '{10'h000, 10'h123, 10'h2C5, 10'h30F};

  mps_sequencer #(.PWR_DGL_CYC(PWR), .INIT_CYC(5), .OFS_WAIT_CYC(OFSW),
    .DOWN_STEP_CYC(5)) mps_sequencer_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .power_request_in_i(preq),
    .colour_select_bit0_i(sel0), .colour_select_bit1_i(sel1),
    .rail_fault_i(fault), .spi_clk_i(sclk), .spi_csn_i(csn),
    .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_o(dout_oe),
    .mirror_offset_rail_o(ofs), .mirror_bias_rail_o(bias),
    .mirror_reset_rail_o(rrail), .mirror_array_init_o(init),
    .system_reset_n_o(sys_n), .interrupt_n_o(int_n),
    .led_driver_en_o(led_en), .led_switch_o(sw), .led_current_o(cur));
  mps_ctrl_model mps_ctrl_model_inst (.spi_clk_o(sclk), .spi_csn_o(csn),
    .spi_din_o(din), .spi_dout_i(dout));

  // Compare tasks, one per kind of result
  task check_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task check_vec(input logic [9:0] got, input logic [9:0] exp,
                 input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task check_range(input int got, input int lo, input int hi,
                   input string msg);
    compares++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH at %0t: %s (%0d)", $time, msg, got);
    end
  endtask
  // Inputs move 1 ns after the edge so no race with sampling
  task tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  // Bounded wait on a monitored bit; n holds the cycles spent
  task wait_bit(input int b, input logic lvl, input int max);
    n = 0;
    while (mon[b] !== lvl && n < max) begin
      tick(1);
      n++;
    end
  endtask

  task test_reset;
    rstn_i = 1'b0;
    tick(5);
    check_bit(sys_n, 1'b0, "reset out high in reset");
    check_bit(int_n, 1'b1, "interrupt low in reset");
    check_bit(ofs, 1'b0, "rail on in reset");
    check_vec(cur, 10'h000, "current set in reset");
    rstn_i = 1'b1;
    tick(2);
    $display("test_reset done");
  endtask
  // Writes while off, colour code ignored, output enable follows select
  task test_writes;
    {sel1, sel0} = 2'b01;
    mps_ctrl_model_inst.send(16'h1123);
    mps_ctrl_model_inst.send(16'h22C5);
    mps_ctrl_model_inst.send(16'h330F);
    fork
      mps_ctrl_model_inst.send(16'h5000);
      begin tick(100); check_bit(dout_oe, 1'b1, "not driving"); end
    join
    tick(6);
    check_bit(dout_oe, 1'b0, "dout not released");
    check_vec({7'h00, sw}, 10'h000, "switch closed when off");
    $display("test_writes done");
  endtask
  task test_power_up;
    preq = 1'b1;
    tick(PWR - 6);
    preq = 1'b0;
    tick(PWR + 10);
    check_bit(init, 1'b0, "short request acted on");
    preq = 1'b1;
    wait_bit(2, 1'b1, 100);
    check_range(n, PWR, PWR + 6, "request filter time");
    wait_bit(3, 1'b1, 100);
    check_range(n, 5, 9, "init to offset delay");
    check_bit(bias, 1'b0, "bias with offset");
    wait_bit(4, 1'b1, 200);
    check_range(n, OFSW - 1, OFSW + 1, "offset to bias");
    check_bit(rrail, 1'b1, "reset rail not with bias");
    check_bit(led_en, 1'b0, "led driver before rails");
    tick(2);
    check_bit(led_en, 1'b1, "led driver not enabled");
    check_bit(sys_n, 1'b1, "system reset not released");
    $display("test_power_up done");
  endtask
  // Every colour code, then a short glitch
  task test_colour;
    for (int c = 0; c < 4; c++) begin
      {sel1, sel0} = 2'(c);
      tick(40);
      check_vec({7'h00, sw}, c == 0 ? 10'h000 : 10'h001 << (c - 1),
                "switch map");
      check_vec(cur, exp_cur[c], "led current");
    end
    {sel1, sel0} = 2'b01;
    tick(8);
    check_vec({7'h00, sw}, 10'h004, "colour glitch passed");
    {sel1, sel0} = 2'b11;
    tick(40);
    check_vec({7'h00, sw}, 10'h004, "colour lost after glitch");
    $display("test_colour done");
  endtask
  task test_power_down;
    preq = 1'b0;
    wait_bit(4, 1'b0, PWR + 20);
    check_range(n, PWR, PWR + 6, "request low to bias drop");
    check_bit(rrail, 1'b0, "reset rail stays on");
    check_bit(ofs, 1'b1, "offset dropped with bias");
    wait_bit(3, 1'b0, 20);
    check_range(n, 3, 8, "offset drop delay");
    check_bit(led_en, 1'b0, "led driver left on");
    $display("test_power_down done");
  endtask
  // Fault drops all rails together; masked fault keeps interrupt high
  task test_fault(input logic [2:0] bits, input logic masked);
    fault = bits;
    wait_bit(3, 1'b0, 8);
    check_range(n, 1, 5, "fault shutdown time");
    check_bit(bias, 1'b0, "bias after fault");
    check_bit(rrail, 1'b0, "reset rail after fault");
    mps_ctrl_model_inst.send(16'h5000);
    check_vec({2'b00, mps_ctrl_model_inst.rx_reg[7:0]}, 10'h001,
              "status byte");
    tick(2);
    check_bit(int_n, masked, "interrupt level");
    preq = 1'b0;
    fault = 3'b000;
    tick(PWR + 10);
    check_bit(int_n, 1'b1, "interrupt held");
    $display("test_fault done");
  endtask

  task final_report;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Watchdog: the run needs well under 60 us
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    fail_count = 0;
    compares = 0;
    preq = 1'b0;
    sel0 = 1'b0;
    sel1 = 1'b0;
    fault = 3'b000;
    test_reset();
    test_writes();
    test_power_up();
    test_colour();
    test_power_down();
    test_power_up();
    test_fault(3'b010, 1'b0);
    mps_ctrl_model_inst.send(16'h4001);
    tick(1);
    test_power_up();
    test_fault(3'b100, 1'b1);
    // Mid-run reset must also clear the fault mask
    test_reset();
    test_power_up();
    test_fault(3'b001, 1'b0);
    final_report();
  end
endmodule // mps_sequencer_tb
